// ===== hdl/bpsi_pkg.sv
// Constants and state types for the battery and power status indicator.
// Assumes one 125 MHz system clock; every slower rate comes from the timebase tick.
`default_nettype none
package bpsi_pkg;
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned TICK_MS       = 250;
   localparam int unsigned TICK_CYC_DFLT = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned PHASE_W       = 3;
   localparam int unsigned STD_DELAY_S   = 120;
   localparam int unsigned STD_TICKS     = STD_DELAY_S * 1000 / TICK_MS;
   localparam int unsigned HOLD_S        = 4;
   localparam int unsigned HOLD_TICKS    = HOLD_S * 1000 / TICK_MS;
   localparam int unsigned IDLE_S        = 60;
   localparam int unsigned IDLE_TICKS    = IDLE_S * 1000 / TICK_MS;
   localparam logic [6:0]  WARN_PCT      = 7'h0a;
   localparam logic [6:0]  LOW_PCT       = 7'h05;
   localparam logic [15:0] DEAD_MV       = 16'h2cec;
   localparam logic [8:0]  STD_TICKS_W   = 9'(STD_TICKS);
   localparam logic [4:0]  HOLD_TICKS_W  = 5'(HOLD_TICKS);
   localparam logic [7:0]  IDLE_TICKS_W  = 8'(IDLE_TICKS);

   typedef enum logic [3:0] {
      BST_NORM = 4'b0001,
      BST_WARN = 4'b0010,
      BST_LOW  = 4'b0100,
      BST_DEAD = 4'b1000
   } bpsi_bst_t;

   typedef enum logic [2:0] {
      PM_FULL = 3'b001,
      PM_DOZE = 3'b010,
      PM_STBY = 3'b100
   } bpsi_pm_t;
endpackage
`default_nettype wire

// ===== hdl/bpsi_tb_if.sv
// Timebase carrier: quarter-second tick and the shared phase count.
// Assumes a single driver (the timebase) and any number of readers.
`timescale 1ns/1ps
`default_nettype none
interface bpsi_tb_if;
   logic                        tick;   // One-cycle pulse every 250 ms
   logic [bpsi_pkg::PHASE_W-1:0] phase; // Tick count within a 2 s cycle
   modport src (output tick, output phase);
   modport snk (input tick, input phase);
endinterface
`default_nettype wire

// ===== hdl/bpsi_timebase.sv
// Free-running timebase shared by all blink, beep and timeout logic.
// Assumes clk_sys and rstn of the top; TICK_CYC may be shortened in simulation.
`timescale 1ns/1ps
`default_nettype none
module bpsi_timebase #(
   parameter int unsigned TICK_CYC = bpsi_pkg::TICK_CYC_DFLT
) (
   input  wire logic clk_sys, // System clock
   input  wire logic rstn,    // Async reset, active low
   bpsi_tb_if.src    tb       // Tick and phase out
);
   logic [31:0]                  div_r,   div_nxt;
   logic [bpsi_pkg::PHASE_W-1:0] phase_r, phase_nxt;
   logic                         tick_r,  tick_nxt;

   // Divider and phase next values
   always_comb
   begin
      div_nxt   = div_r + 32'h1;
      tick_nxt  = 1'b0;
      phase_nxt = phase_r;
      if (div_r >= 32'(TICK_CYC - 1))
      begin
         div_nxt   = 32'h0;
         tick_nxt  = 1'b1;
         phase_nxt = phase_r + 3'h1;
      end
   end

   // Divider registers
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         div_r   <= 32'h0;
         phase_r <= 3'h0;
         tick_r  <= 1'b0;
      end
      else
      begin
         div_r   <= div_nxt;
         phase_r <= phase_nxt;
         tick_r  <= tick_nxt;
      end
   end

   assign tb.tick  = tick_r;
   assign tb.phase = phase_r;

   // Phase moves only with a tick
   chk_phase_on_tick: assert property (@(posedge clk_sys) disable iff (!rstn)
      !tick_r |-> phase_r == $past(phase_r))
      else $error("phase moved without a tick");
endmodule // bpsi_timebase
`default_nettype wire

// ===== hdl/bpsi_btn_hold.sv
// Power button hold detector: forces the system off after a long press.
// Assumes the button input is synchronous and already debounced.
`timescale 1ns/1ps
`default_nettype none
module bpsi_btn_hold (
   input  wire logic clk_sys,   // System clock
   input  wire logic rstn,      // Async reset, active low
   bpsi_tb_if.snk    tb,        // Timebase
   input  wire logic pwr_btn,   // Power button pressed, high
   input  wire logic acpi_mode, // Button handled in ACPI mode
   output logic      force_off  // Held longer than the limit
);
   logic [4:0] hold_r, hold_nxt;

   // Hold counter, saturating one past the limit
   always_comb
   begin
      hold_nxt = hold_r;
      if (!pwr_btn || !acpi_mode)
         hold_nxt = 5'h0;
      else if (tb.tick && hold_r <= bpsi_pkg::HOLD_TICKS_W)
         hold_nxt = hold_r + 5'h1;
   end

   // Hold counter register
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         hold_r <= 5'h0;
      else
         hold_r <= hold_nxt;
   end

   assign force_off = hold_r > bpsi_pkg::HOLD_TICKS_W;

   // Force only while the button is still held in ACPI mode
   chk_force_needs_btn: assert property (@(posedge clk_sys) disable iff (!rstn)
      force_off |-> $past(pwr_btn) && $past(acpi_mode))
      else $error("force off without a held button");
endmodule // bpsi_btn_hold
`default_nettype wire

// ===== hdl/bpsi_top.sv
// Battery and power status indicator: LEDs, beeper, battery sequences and
// simple power-management requests.
// Assumes all inputs synchronous to clk_sys; capacity in percent, voltage in mV.
//
// Overview of operation
// - AC LED steady on while running from AC and not suspended.
// - AC LED blinks 1 s on, 1 s off in suspend-to-RAM, any source.
// - AC LED dark when powered off or running from battery.
// - Battery power LED on while running from battery.
// - Battery power LED blinks 1 s on, 1 s off when battery low.
// - Battery power LED dark when off or on AC.
// - Status LED off on battery while charge stays above warning level.
// - At 10 percent, status LED blinks red; beep once every 2 s.
// - With AC, status LED green when full, amber while charging.
// - Request suspend-to-disk two minutes after entering battery warning.
// - After warning, below 5 percent, beep twice every second.
// - At the dead voltage threshold, shut the system down.
// - Doze mode alternates the processor between running and stop grant.
// - Standby: stop grant, backlight off, disk spin-down request.
// - Idle on enabled display or disk monitors advances power state.
// - Power button held over 4 s in ACPI mode forces off.
`timescale 1ns/1ps
`default_nettype none
module bpsi_top #(
   parameter int unsigned TICK_CYC = bpsi_pkg::TICK_CYC_DFLT
) (
   input  wire logic        clk_sys,       // System clock, 125 MHz
   input  wire logic        rstn,          // Async reset, active low
   input  wire logic        ac_present,    // AC adapter supplies power
   input  wire logic        sys_on,        // System running (not off)
   input  wire logic        str_active,    // Suspend-to-RAM in effect
   input  wire logic [6:0]  cap_pct,       // Battery charge, percent
   input  wire logic [15:0] batt_mv,       // Battery voltage, mV
   input  wire logic        batt_full,     // Pack fully charged
   input  wire logic        batt_charging, // Pack being charged
   input  wire logic        pwr_btn,       // Power button pressed
   input  wire logic        acpi_mode,     // ACPI power button mode
   input  wire logic        doze_en,       // Doze state allowed
   input  wire logic        vid_mon_en,    // Display activity monitor on
   input  wire logic        dsk_mon_en,    // Disk activity monitor on
   input  wire logic        vid_act,       // Display activity seen
   input  wire logic        dsk_act,       // Disk activity seen
   output logic             led_ac,        // AC power LED
   output logic             led_batt,      // Battery power LED
   output logic             led_red,       // Status LED red
   output logic             led_green,     // Status LED green
   output logic             led_amber,     // Status LED amber
   output logic             beep,          // Beeper drive
   output logic             req_std,       // Suspend-to-disk request pulse
   output logic             req_shutdown,  // Dead battery shutdown request
   output logic             req_force_off, // Long-press force off
   output logic             cpu_stpgnt,    // Processor stop grant
   output logic             backlight_off, // Panel backlight off
   output logic             disk_spindown, // Disk spin-down request
   output logic [2:0]       pm_state       // Power-management state
);
   bpsi_tb_if tb ();

   // Shared timebase
   bpsi_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tb      (tb.src)
   );

   // Long-press detector
   bpsi_btn_hold u_hold (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .tb        (tb.snk),
      .pwr_btn   (pwr_btn),
      .acpi_mode (acpi_mode),
      .force_off (req_force_off)
   );

   logic blink_on;
   logic on_batt;
   logic dead_lvl;
   assign blink_on = ~tb.phase[2];                  // On for the first second
   assign on_batt  = sys_on & ~ac_present;
   assign dead_lvl = batt_mv <= bpsi_pkg::DEAD_MV;

   // ------------------------------------------------------------
   // Battery sequence
   bpsi_pkg::bpsi_bst_t bst_r, bst_nxt;
   logic [8:0]          warn_r, warn_nxt;
   logic                std_r, std_nxt;

   // Battery state and warning timer next values
   always_comb
   begin
      bst_nxt  = bst_r;
      warn_nxt = warn_r;
      std_nxt  = 1'b0;
      if (!on_batt)
         bst_nxt = bpsi_pkg::BST_NORM;
      else
      begin
         case (bst_r)
            bpsi_pkg::BST_NORM:
               if (dead_lvl)
                  bst_nxt = bpsi_pkg::BST_DEAD;
               else if (cap_pct <= bpsi_pkg::WARN_PCT)
                  bst_nxt = bpsi_pkg::BST_WARN;
            bpsi_pkg::BST_WARN:
               if (dead_lvl)
                  bst_nxt = bpsi_pkg::BST_DEAD;
               else if (cap_pct < bpsi_pkg::LOW_PCT)
                  bst_nxt = bpsi_pkg::BST_LOW;
               else if (cap_pct > bpsi_pkg::WARN_PCT)
                  bst_nxt = bpsi_pkg::BST_NORM;
            bpsi_pkg::BST_LOW:
               if (dead_lvl)
                  bst_nxt = bpsi_pkg::BST_DEAD;
            bpsi_pkg::BST_DEAD:
               bst_nxt = bpsi_pkg::BST_DEAD;
            default:
               bst_nxt = bpsi_pkg::BST_NORM;
         endcase
      end
      // Timer runs from warning entry through the low state
      if (bst_nxt == bpsi_pkg::BST_NORM || bst_nxt == bpsi_pkg::BST_DEAD)
         warn_nxt = 9'h0;
      else if (tb.tick && warn_r < bpsi_pkg::STD_TICKS_W)
      begin
         warn_nxt = warn_r + 9'h1;
         std_nxt  = (warn_r + 9'h1) == bpsi_pkg::STD_TICKS_W;
      end
   end

   // Battery state registers
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         bst_r  <= bpsi_pkg::BST_NORM;
         warn_r <= 9'h0;
         std_r  <= 1'b0;
      end
      else
      begin
         bst_r  <= bst_nxt;
         warn_r <= warn_nxt;
         std_r  <= std_nxt;
      end
   end

   assign req_std      = std_r;
   assign req_shutdown = bst_r == bpsi_pkg::BST_DEAD;

   // ------------------------------------------------------------
   // Indicators and beeper
   logic ac_r, ac_nxt, bat_r, bat_nxt;
   logic red_r, red_nxt, grn_r, grn_nxt, amb_r, amb_nxt, beep_r, beep_nxt;
   logic batt_lowish;
   assign batt_lowish = bst_r != bpsi_pkg::BST_NORM;

   // LED and beeper next values
   always_comb
   begin
      ac_nxt   = 1'b0;
      bat_nxt  = 1'b0;
      red_nxt  = 1'b0;
      grn_nxt  = 1'b0;
      amb_nxt  = 1'b0;
      beep_nxt = 1'b0;
      if (str_active)
         ac_nxt = blink_on;
      else if (sys_on && ac_present)
         ac_nxt = 1'b1;
      if (on_batt && !str_active)
      begin
         if (batt_lowish)
            bat_nxt = blink_on;
         else
            bat_nxt = 1'b1;
      end
      if (ac_present)
      begin
         grn_nxt = batt_full;
         amb_nxt = batt_charging & ~batt_full;
      end
      else if (on_batt && batt_lowish)
         red_nxt = blink_on;
      if (on_batt && bst_r == bpsi_pkg::BST_WARN)
         beep_nxt = tb.phase == 3'h0;
      else if (on_batt && bst_r == bpsi_pkg::BST_LOW)
         beep_nxt = ~tb.phase[0];
   end

   // LED and beeper registers
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ac_r   <= 1'b0;
         bat_r  <= 1'b0;
         red_r  <= 1'b0;
         grn_r  <= 1'b0;
         amb_r  <= 1'b0;
         beep_r <= 1'b0;
      end
      else
      begin
         ac_r   <= ac_nxt;
         bat_r  <= bat_nxt;
         red_r  <= red_nxt;
         grn_r  <= grn_nxt;
         amb_r  <= amb_nxt;
         beep_r <= beep_nxt;
      end
   end

   assign led_ac    = ac_r;
   assign led_batt  = bat_r;
   assign led_red   = red_r;
   assign led_green = grn_r;
   assign led_amber = amb_r;
   assign beep      = beep_r;

   // ------------------------------------------------------------
   // Power-management states
   bpsi_pkg::bpsi_pm_t pm_r, pm_nxt;
   logic [7:0]         idle_r, idle_nxt;
   logic               stg_r, stg_nxt;
   logic               monitored, active;
   assign monitored = vid_mon_en | dsk_mon_en;
   assign active    = (vid_mon_en & vid_act) | (dsk_mon_en & dsk_act);

   // Idle timer, state and throttle next values
   always_comb
   begin
      pm_nxt   = pm_r;
      idle_nxt = idle_r;
      stg_nxt  = 1'b0;
      if (!sys_on || active || !monitored)
      begin
         pm_nxt   = bpsi_pkg::PM_FULL;
         idle_nxt = 8'h0;
      end
      else if (tb.tick)
      begin
         idle_nxt = idle_r + 8'h1;
         if (idle_nxt == bpsi_pkg::IDLE_TICKS_W)
         begin
            idle_nxt = 8'h0;
            case (pm_r)
               bpsi_pkg::PM_FULL: pm_nxt = doze_en ? bpsi_pkg::PM_DOZE : bpsi_pkg::PM_STBY;
               bpsi_pkg::PM_DOZE: pm_nxt = bpsi_pkg::PM_STBY;
               default:           pm_nxt = bpsi_pkg::PM_STBY;
            endcase
         end
      end
      case (pm_nxt)
         bpsi_pkg::PM_DOZE: stg_nxt = tb.tick ? ~stg_r : stg_r;
         bpsi_pkg::PM_STBY: stg_nxt = 1'b1;
         default:           stg_nxt = 1'b0;
      endcase
   end

   // Power-management registers
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pm_r   <= bpsi_pkg::PM_FULL;
         idle_r <= 8'h0;
         stg_r  <= 1'b0;
      end
      else
      begin
         pm_r   <= pm_nxt;
         idle_r <= idle_nxt;
         stg_r  <= stg_nxt;
      end
   end

   assign cpu_stpgnt    = stg_r;
   assign backlight_off = pm_r == bpsi_pkg::PM_STBY;
   assign disk_spindown = pm_r == bpsi_pkg::PM_STBY;
   assign pm_state      = pm_r;

   // ------------------------------------------------------------
   // Checks
   chk_ac_led_steady: assert property (@(posedge clk_sys) disable iff (!rstn)
      sys_on && ac_present && !str_active |=> led_ac)
      else $error("AC LED not lit while on AC");
   chk_ac_led_blink: assert property (@(posedge clk_sys) disable iff (!rstn)
      str_active |=> led_ac == $past(blink_on))
      else $error("AC LED not blinking in suspend");
   chk_ac_led_dark: assert property (@(posedge clk_sys) disable iff (!rstn)
      !str_active && (!sys_on || !ac_present) |=> !led_ac)
      else $error("AC LED lit when off or on battery");
   chk_batt_led_dark: assert property (@(posedge clk_sys) disable iff (!rstn)
      !sys_on || ac_present |=> !led_batt)
      else $error("battery LED lit when off or on AC");
   chk_batt_led_low: assert property (@(posedge clk_sys) disable iff (!rstn)
      on_batt && !str_active && batt_lowish |=> led_batt == $past(blink_on))
      else $error("battery LED not blinking when low");
   chk_status_colour: assert property (@(posedge clk_sys) disable iff (!rstn)
      ac_present |=> !led_red && led_green == $past(batt_full))
      else $error("status LED colour wrong on AC");
   chk_dead_shut: assert property (@(posedge clk_sys) disable iff (!rstn)
      on_batt && dead_lvl ##1 on_batt |=> req_shutdown)
      else $error("no shutdown at dead voltage");
   chk_std_timing: assert property (@(posedge clk_sys) disable iff (!rstn)
      req_std |-> warn_r == bpsi_pkg::STD_TICKS_W && !$past(req_std))
      else $error("suspend-to-disk request off time");
   chk_low_beep: assert property (@(posedge clk_sys) disable iff (!rstn)
      on_batt && bst_r == bpsi_pkg::BST_LOW |=> beep == ~$past(tb.phase[0]))
      else $error("low battery beep pattern wrong");
   chk_stby_outputs: assert property (@(posedge clk_sys) disable iff (!rstn)
      pm_r == bpsi_pkg::PM_STBY |-> cpu_stpgnt && backlight_off && disk_spindown)
      else $error("standby outputs incomplete");
   chk_doze_toggle: assert property (@(posedge clk_sys) disable iff (!rstn)
      pm_r == bpsi_pkg::PM_DOZE && pm_nxt == bpsi_pkg::PM_DOZE && tb.tick
      |=> cpu_stpgnt != $past(cpu_stpgnt))
      else $error("doze did not toggle stop grant");
endmodule // bpsi_top
`default_nettype wire

// ===== verif/bpsi_pack_model.sv
// Battery pack and adapter model: AC sense, charge, voltage, full and charging.
// Assumes commands from the bench; outputs change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module bpsi_pack_model (
   input  wire logic        clk_sys,      // System clock
   input  wire logic        cmd_ac,       // Adapter plugged in
   input  wire logic [6:0]  cmd_cap,      // Charge to present, percent
   input  wire logic [15:0] cmd_mv,       // Voltage to present, mV
   output logic             ac_present,   // AC sense
   output logic [6:0]       cap_pct,      // Charge, percent
   output logic [15:0]      batt_mv,      // Pack voltage, mV
   output logic             batt_full,    // Pack full
   output logic             batt_charging // Pack taking charge
);
   // Quiet pack at time zero
   initial
   begin
      ac_present = 1'b0;
      cap_pct = 7'h00;
      batt_mv = 16'h3a98;
      batt_full = 1'b0;
      batt_charging = 1'b0;
   end

   // Commands taken at the edge, driven 1 ns later; full at 100 percent, else charging on AC
   always @(posedge clk_sys)
   begin
      ac_present    <= #1 cmd_ac;
      cap_pct       <= #1 cmd_cap;
      batt_mv       <= #1 cmd_mv;
      batt_full     <= #1 cmd_ac && (cmd_cap >= 7'h64);
      batt_charging <= #1 cmd_ac && (cmd_cap < 7'h64);
   end
endmodule // bpsi_pack_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the status indicator, timebase shortened to 4 cycles.
// Assumes the pack model supplies the battery inputs; the rest come from here.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_sys, rstn, sys_on, str_active, pwr_btn, acpi_mode, doze_en;
   logic        vid_mon_en, dsk_mon_en, vid_act, dsk_act, cmd_ac;
   logic        ac_present, batt_full, batt_charging;
   logic [6:0]  cmd_cap, cap_pct;
   logic [15:0] cmd_mv, batt_mv;
   logic        led_ac, led_batt, led_red, led_green, led_amber, beep, req_std;
   logic        req_shutdown, req_force_off, cpu_stpgnt, backlight_off, disk_spindown;
   logic [2:0]  pm_state;
   int          err_total, cmp_count, cyc, t0, i;
   int          cnt[8];

   bpsi_pack_model bpsi_pack_model_inst (.clk_sys(clk_sys), .cmd_ac(cmd_ac),
      .cmd_cap(cmd_cap), .cmd_mv(cmd_mv), .ac_present(ac_present), .cap_pct(cap_pct),
      .batt_mv(batt_mv), .batt_full(batt_full), .batt_charging(batt_charging));

   bpsi_top #(.TICK_CYC(4)) bpsi_top_inst (.clk_sys(clk_sys), .rstn(rstn),
      .ac_present(ac_present), .sys_on(sys_on), .str_active(str_active),
      .cap_pct(cap_pct), .batt_mv(batt_mv), .batt_full(batt_full),
      .batt_charging(batt_charging), .pwr_btn(pwr_btn), .acpi_mode(acpi_mode),
      .doze_en(doze_en), .vid_mon_en(vid_mon_en), .dsk_mon_en(dsk_mon_en),
      .vid_act(vid_act), .dsk_act(dsk_act), .led_ac(led_ac), .led_batt(led_batt),
      .led_red(led_red), .led_green(led_green), .led_amber(led_amber), .beep(beep),
      .req_std(req_std), .req_shutdown(req_shutdown), .req_force_off(req_force_off),
      .cpu_stpgnt(cpu_stpgnt), .backlight_off(backlight_off),
      .disk_spindown(disk_spindown), .pm_state(pm_state));

   // 125 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Apply a supply condition and let it reach the LEDs
   task automatic env(input logic ac, on, str, input logic [6:0] cap, input logic [15:0] mv);
      cmd_ac = ac;
      sys_on = on;
      str_active = str;
      cmd_cap = cap;
      cmd_mv = mv;
      t0 = cyc;
      step(5);
   endtask

   // One 2 s window: lit cycles, beep starts, stop-grant toggles, LED phase skew
   task automatic win();
      logic b0, s0;
      cnt = '{default:0};
      b0 = beep;
      s0 = cpu_stpgnt;
      repeat (32)
      begin
         step(1);
         cnt[0] += (led_ac === 1'b1);
         cnt[1] += (led_batt === 1'b1);
         cnt[2] += (led_red === 1'b1);
         cnt[3] += (led_green === 1'b1);
         cnt[4] += (led_amber === 1'b1);
         cnt[5] += (beep === 1'b1 && b0 !== 1'b1);
         cnt[6] += (cpu_stpgnt !== s0);
         cnt[7] += (led_red === 1'b1 && led_batt !== 1'b1);
         b0 = beep;
         s0 = cpu_stpgnt;
      end
   endtask

   task automatic leds(input logic [15:0] a, b, r, g, m);
      check(16'(cnt[0]), a);
      check(16'(cnt[1]), b);
      check(16'(cnt[2]), r);
      check(16'(cnt[3]), g);
      check(16'(cnt[4]), m);
   endtask

   // Bounded wait for a completion condition
   task automatic wait_hi(input int sel, input int lim);
      logic hit;
      int   n;
      hit = 1'b0;
      n = 0;
      while (!hit && n < lim)
      begin
         step(1);
         n++;
         case (sel)
            0: hit = (req_std === 1'b1);
            1: hit = (pm_state === 3'b010);
            2: hit = (pm_state === 3'b100);
            default: hit = (req_force_off === 1'b1);
         endcase
      end
   endtask

   function automatic logic [15:0] in_rng(input int lo, hi);
      return 16'(cyc - t0 >= lo && cyc - t0 <= hi);
   endfunction

   // Cycle ceiling against hangs
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge clk_sys);
         cyc++;
         if (cyc == 12000)
         begin
            err_total++;
            conclude();
         end
      end
   end

   // Main sequence
   initial
   begin
      void'($urandom(7));
      {rstn, sys_on, str_active, pwr_btn, acpi_mode, doze_en} = 6'h00;
      {vid_mon_en, dsk_mon_en, vid_act, dsk_act, cmd_ac} = 5'h00;
      cmd_cap = 7'h64;
      cmd_mv = 16'h3a98;
      err_total = 0;
      cmp_count = 0;
      step(9);
      check({led_ac, led_batt, led_red, led_green, led_amber, beep, req_std}, 16'h0);
      check({req_shutdown, req_force_off, cpu_stpgnt, backlight_off, disk_spindown}, 16'h0);
      check(16'(pm_state), 16'h1);
      step(1);
      rstn = 1'b1;
      step(2);
      // On AC: steady AC LED, status green when full, amber while charging
      env(1'b1, 1'b1, 1'b0, 7'h64, 16'h3a98);
      win();
      leds(16'h20, 16'h0, 16'h0, 16'h20, 16'h0);
      env(1'b1, 1'b1, 1'b0, 7'(11 + $urandom % 89), 16'h3a98);
      win();
      leds(16'h20, 16'h0, 16'h0, 16'h0, 16'h20);
      // Suspend-to-RAM blinks the AC LED on either source
      for (i = 0; i < 2; i++)
      begin
         env(1'(i == 0), 1'b1, 1'b1, 7'h32, 16'h3a98);
         win();
         check(16'(cnt[0]), 16'h10);
      end
      // Powered off: both power LEDs dark
      env(1'b0, 1'b0, 1'b0, 7'h32, 16'h3a98);
      win();
      leds(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      // Battery above the warning level, random charge and voltage
      for (i = 0; i < 3; i++)
      begin
         env(1'b0, 1'b1, 1'b0, 7'(11 + $urandom % 90), 16'(11501 + $urandom % 5000));
         win();
         leds(16'h0, 16'h20, 16'h0, 16'h0, 16'h0);
         check(16'(cnt[5]), 16'h0);
      end
      // Warning at 10 and 5 percent, then low below 5 percent
      env(1'b0, 1'b1, 1'b0, 7'h0a, 16'h3a98);
      i = t0;
      win();
      leds(16'h0, 16'h10, 16'h10, 16'h0, 16'h0);
      check(16'(cnt[5]), 16'h1);
      check(16'(cnt[7]), 16'h0);
      cmd_cap = 7'h05;
      step(5);
      win();
      check(16'(cnt[5]), 16'h1);
      cmd_cap = 7'(1 + $urandom % 4);
      step(5);
      win();
      check(16'(cnt[5]), 16'h4);
      check(16'(cnt[2]), 16'h10);
      // Suspend-to-disk request two minutes after entering warning
      t0 = i;
      wait_hi(0, 2200);
      check(in_rng(1910, 1935), 16'h1);
      step(1);
      check(16'(req_std), 16'h0);
      // Dead threshold: one millivolt above, then at it, then AC returns
      env(1'b0, 1'b1, 1'b0, 7'h32, 16'h2ced);
      check(16'(req_shutdown), 16'h0);
      env(1'b0, 1'b1, 1'b0, 7'h32, 16'h2cec);
      check(16'(req_shutdown), 16'h1);
      env(1'b1, 1'b1, 1'b0, 7'h64, 16'h3a98);
      check(16'(req_shutdown), 16'h0);
      // Idle display to doze, then stop grant toggles on every tick
      {vid_mon_en, doze_en} = 2'b11;
      t0 = cyc;
      wait_hi(1, 1200);
      check(in_rng(950, 975), 16'h1);
      t0 = cyc;
      win();
      check(16'(cnt[6]), 16'h8);
      // Still idle in doze: next step is standby
      wait_hi(2, 1200);
      check(in_rng(950, 970), 16'h1);
      check({cpu_stpgnt, backlight_off, disk_spindown, pm_state}, 16'h3c);
      vid_act = 1'b1;
      step(3);
      check({cpu_stpgnt, pm_state}, 16'h1);
      {vid_act, vid_mon_en, doze_en, dsk_mon_en} = 4'h1;
      // Idle disk without doze goes straight to standby
      wait_hi(2, 1200);
      check({cpu_stpgnt, backlight_off, disk_spindown, pm_state}, 16'h3c);
      dsk_act = 1'b1;
      step(3);
      check({cpu_stpgnt, backlight_off, disk_spindown, pm_state}, 16'h1);
      dsk_act = 1'b0;
      // Long press in ACPI mode forces off; outside ACPI it does not
      {acpi_mode, pwr_btn} = 2'b11;
      t0 = cyc;
      wait_hi(3, 200);
      check(in_rng(62, 76), 16'h1);
      pwr_btn = 1'b0;
      step(2);
      check(16'(req_force_off), 16'h0);
      {acpi_mode, pwr_btn} = 2'b01;
      step(100);
      check(16'(req_force_off), 16'h0);
      pwr_btn = 1'b0;
      step(2);
      conclude();
   end
endmodule // tb
`default_nettype wire
